/* pdc_pkg.sv */
// package for the pll divider control block
package pdc_pkg;

	// register indices as printed; byte address is four times the index
	localparam logic [7:0]  PDC_IDX_CONTROL     = 8'hE9;
	localparam logic [7:0]  PDC_IDX_REF_DIV     = 8'hEE;
	localparam logic [7:0]  PDC_IDX_FB_DIV_HIGH = 8'hEF;
	localparam int          PDC_ADDR_W          = 12;
	localparam logic [11:0] PDC_ADDR_CONTROL    = {2'b00, PDC_IDX_CONTROL, 2'b00};
	localparam logic [11:0] PDC_ADDR_REF_DIV    = {2'b00, PDC_IDX_REF_DIV, 2'b00};
	localparam logic [11:0] PDC_ADDR_FB_HIGH    = {2'b00, PDC_IDX_FB_DIV_HIGH, 2'b00};

	// control register fields
	localparam int          PDC_CTL_LOCK_BIT    = 0;
	localparam int          PDC_CTL_EN_BIT      = 1;
	localparam int          PDC_CTL_RES_BIT     = 3;
	localparam int          PDC_CTL_FBLO_LSB    = 6;
	localparam int          PDC_CTL_FBLO_MSB    = 7;

	// reset values
	localparam logic [7:0]  PDC_CONTROL_RST     = 8'h08;
	localparam logic [7:0]  PDC_REF_DIV_RST     = 8'h00;
	localparam logic [7:0]  PDC_FB_HIGH_RST     = 8'h00;
	localparam logic [31:0] PDC_READ_ZERO       = 32'h0000_0000;

	localparam int          PDC_REF_DIV_W       = 7;
	localparam int          PDC_FB_DIV_W        = 10;

	// signals to the analog core travel together
	typedef struct packed {
		logic                       hold_reset;
		logic                       run_enable;
		logic [PDC_REF_DIV_W-1:0]   ref_div_value;
		logic [PDC_FB_DIV_W-1:0]    fb_div_value;
	} pdc_core_ctl_t;

endpackage : pdc_pkg

/* pdc_pll_divider_control.sv */
// pll control and divider registers behind an apb slave
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps

module pdc_pll_divider_control
	import pdc_pkg::*;
(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [PDC_ADDR_W-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic                       pready,
	output logic [31:0]                prdata,
	output logic                       pslverr,
	input  wire logic                  phase_compare_lock_detect,
	output pdc_core_ctl_t              core_ctl
);

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic       pll_hold_reset;
	logic       pll_run_enable;
	logic [1:0] feedback_div_low_bits;
	logic [PDC_REF_DIV_W-1:0] ref_div_value;
	logic [7:0] pll_feedback_divider_high;
	logic       lock_indicator;

	logic       access;
	logic       wr_ok;
	logic       mapped;
	logic [7:0] control_view;

	// ------------------------------------------------------------
	// decoded selects
	// ------------------------------------------------------------
	logic       sel_control;
	logic       sel_ref_div;
	logic       sel_fb_high;
	logic       rd_setup;

	assign sel_control = (paddr == PDC_ADDR_CONTROL);
	assign sel_ref_div = (paddr == PDC_ADDR_REF_DIV);
	assign sel_fb_high = (paddr == PDC_ADDR_FB_HIGH);
	assign rd_setup    = psel && !penable && !pwrite;

	function automatic logic addr_mapped(input logic [PDC_ADDR_W-1:0] a);
		return (a == PDC_ADDR_CONTROL) || (a == PDC_ADDR_REF_DIV) || (a == PDC_ADDR_FB_HIGH);
	endfunction : addr_mapped

	assign access  = psel && penable;
	assign mapped  = addr_mapped(paddr);
	assign pready  = 1'b1;
	assign pslverr = access && !mapped;
	assign wr_ok   = access && pwrite && mapped && pstrb[0];

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_hold_reset        <= PDC_CONTROL_RST[PDC_CTL_RES_BIT];
			pll_run_enable        <= PDC_CONTROL_RST[PDC_CTL_EN_BIT];
			feedback_div_low_bits <= PDC_CONTROL_RST[PDC_CTL_FBLO_MSB:PDC_CTL_FBLO_LSB];
		end else if (wr_ok && paddr == PDC_ADDR_CONTROL) begin
			pll_hold_reset        <= pwdata[PDC_CTL_RES_BIT];
			pll_run_enable        <= pwdata[PDC_CTL_EN_BIT];
			feedback_div_low_bits <= pwdata[PDC_CTL_FBLO_MSB:PDC_CTL_FBLO_LSB];
		end
	end

	// ------------------------------------------------------------
	// divider registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_div_value <= PDC_REF_DIV_RST[PDC_REF_DIV_W-1:0];
		end else if (wr_ok && paddr == PDC_ADDR_REF_DIV) begin
			ref_div_value <= pwdata[PDC_REF_DIV_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_feedback_divider_high <= PDC_FB_HIGH_RST;
		end else if (wr_ok && paddr == PDC_ADDR_FB_HIGH) begin
			pll_feedback_divider_high <= pwdata[7:0];
		end
	end

	// ------------------------------------------------------------
	// lock indicator
	// ------------------------------------------------------------
	// forced low from the cycle after hold or disable is set, so a stale core lock shows for at most one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_indicator <= PDC_CONTROL_RST[PDC_CTL_LOCK_BIT];
		end else begin
			lock_indicator <= phase_compare_lock_detect && pll_run_enable && !pll_hold_reset;
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	always_comb begin
		control_view = 8'h00;
		control_view[PDC_CTL_FBLO_MSB:PDC_CTL_FBLO_LSB] = feedback_div_low_bits;
		control_view[PDC_CTL_RES_BIT]  = pll_hold_reset;
		control_view[PDC_CTL_EN_BIT]   = pll_run_enable;
		control_view[PDC_CTL_LOCK_BIT] = lock_indicator;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= PDC_READ_ZERO;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				PDC_ADDR_CONTROL: prdata <= {24'h00_0000, control_view};
				PDC_ADDR_REF_DIV: prdata <= {25'h000_0000, ref_div_value};
				PDC_ADDR_FB_HIGH: prdata <= {24'h00_0000, pll_feedback_divider_high};
				default:          prdata <= PDC_READ_ZERO;
			endcase
		end
	end

	// ------------------------------------------------------------
	// core control outputs
	// ------------------------------------------------------------
	// the analog comparator sees the divided reference and feedback values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_ctl <= '{hold_reset: 1'b1, run_enable: 1'b0, ref_div_value: '0, fb_div_value: '0};
		end else begin
			core_ctl.hold_reset    <= pll_hold_reset;
			core_ctl.run_enable    <= pll_run_enable && !pll_hold_reset;
			core_ctl.ref_div_value <= ref_div_value;
			core_ctl.fb_div_value  <= {pll_feedback_divider_high, feedback_div_low_bits};
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_lock_gated: assert property (@(posedge pclk) disable iff (!presetn)
		(!pll_run_enable || pll_hold_reset) |=> !lock_indicator)
		else $error("lock shown while pll held or disabled");

	a_lock_follow: assert property (@(posedge pclk) disable iff (!presetn)
		(phase_compare_lock_detect && pll_run_enable && !pll_hold_reset) |=> lock_indicator)
		else $error("lock indicator missed core lock");

	a_res_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_ok && paddr == PDC_ADDR_CONTROL) |=> ##1 (core_ctl.hold_reset == $past(pwdata[PDC_CTL_RES_BIT], 2)))
		else $error("hold reset not taken from write");

	a_en_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_ok && paddr == PDC_ADDR_CONTROL) |=> (pll_run_enable == $past(pwdata[PDC_CTL_EN_BIT])))
		else $error("run enable not taken from write");

	a_fb_value: assert property (@(posedge pclk) disable iff (!presetn)
		##1 core_ctl.fb_div_value == $past({pll_feedback_divider_high, feedback_div_low_bits}))
		else $error("feedback divider value wrong");

	a_fb_high: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_ok && paddr == PDC_ADDR_FB_HIGH) |=> ##1 (core_ctl.fb_div_value[9] == $past(pwdata[7], 2)))
		else $error("feedback msb not bit 7 of high register");

	a_ref_div: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_ok && paddr == PDC_ADDR_REF_DIV) |=> ##1 (core_ctl.ref_div_value == $past(pwdata[6:0], 2)))
		else $error("reference divider not taken");

	a_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(control_view[5:4] == 2'b00) && (control_view[2] == 1'b0))
		else $error("reserved control bits not zero");

	a_reset_read: assert property (@(posedge pclk)
		$rose(presetn) |-> (control_view == PDC_CONTROL_RST) && (ref_div_value == '0))
		else $error("reset values wrong");

	a_lock_reset: assert property (@(posedge pclk)
		$rose(presetn) |-> !lock_indicator)
		else $error("lock set right after reset");

	// ------------------------------------------------------------
	// bus assertions
	// ------------------------------------------------------------
	a_ready_high: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable) |-> pready)
		else $error("ready low in access phase");

	a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !mapped) |-> pslverr)
		else $error("no error for unmapped access");

	a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && mapped) |-> !pslverr)
		else $error("error on mapped access");

	a_read_upper: assert property (@(posedge pclk) disable iff (!presetn)
		prdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");

	a_ref_msb_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_setup && sel_ref_div) |=> !prdata[7])
		else $error("reserved reference bit not zero");

	a_ctl_read: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_setup && sel_control) |=> (prdata[7:0] == $past(control_view)))
		else $error("control read data wrong");

	a_fb_read: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_setup && sel_fb_high) |=> (prdata[7:0] == $past(pll_feedback_divider_high)))
		else $error("feedback high read data wrong");

	a_ref_read: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_setup && sel_ref_div) |=> (prdata[6:0] == $past(ref_div_value)))
		else $error("reference read data wrong");

	a_unmapped_read: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_setup && !mapped) |=> (prdata == PDC_READ_ZERO))
		else $error("unmapped read not zero");

	a_prdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!rd_setup |=> $stable(prdata))
		else $error("read data changed outside setup");

	// ------------------------------------------------------------
	// register assertions
	// ------------------------------------------------------------
	a_lock_wr_ignored: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_ok && sel_control && !pwdata[0] && phase_compare_lock_detect && pll_run_enable
			&& !pll_hold_reset) |=> lock_indicator)
		else $error("write cleared lock indicator");

	a_hold_keep: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr_ok && sel_control) |=> $stable(pll_hold_reset))
		else $error("hold reset changed without write");

	a_en_keep: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr_ok && sel_control) |=> $stable(pll_run_enable))
		else $error("run enable changed without write");

	a_fblo_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_ok && sel_control) |=> (feedback_div_low_bits == $past(pwdata[7:6])))
		else $error("feedback low bits not taken");

	a_fbhi_keep: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr_ok && sel_fb_high) |=> $stable(pll_feedback_divider_high))
		else $error("feedback high changed without write");

	a_ref_keep: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr_ok && sel_ref_div) |=> $stable(ref_div_value))
		else $error("reference changed without write");

	a_strobe_gate: assert property (@(posedge pclk) disable iff (!presetn)
		(access && pwrite && !pstrb[0]) |=> ($stable(ref_div_value) && $stable(pll_feedback_divider_high)
			&& $stable(feedback_div_low_bits)))
		else $error("write landed without byte strobe");

	// ------------------------------------------------------------
	// core assertions
	// ------------------------------------------------------------
	a_core_hold: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> (core_ctl.hold_reset == $past(pll_hold_reset)))
		else $error("core hold does not follow register");

	a_core_run: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> (core_ctl.run_enable == $past(pll_run_enable && !pll_hold_reset)))
		else $error("core enable does not follow register");

	a_core_held_off: assert property (@(posedge pclk) disable iff (!presetn)
		core_ctl.hold_reset |-> !core_ctl.run_enable)
		else $error("core enabled while held");

	a_core_ref: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> (core_ctl.ref_div_value == $past(ref_div_value)))
		else $error("core reference does not follow register");

endmodule : pdc_pll_divider_control

/* pdc_core_model.sv */
// behavioural analog core model that answers with a lock level
`timescale 1ns/1ps
module pdc_core_model
	import pdc_pkg::*;
#(
	parameter int LOCK_CYCLES = 20
)
(
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire pdc_core_ctl_t core_ctl,
	input  wire logic          drop_lock,
	output logic               lock
);
	int count;
	// loop only settles after running undisturbed for a while
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= 0;
		end else if (core_ctl.hold_reset || !core_ctl.run_enable || drop_lock) begin
			count <= 0;
		end else if (count < LOCK_CYCLES) begin
			count <= count + 1;
		end
	end
	assign lock = (count == LOCK_CYCLES);
endmodule : pdc_core_model

/* pll_divider_control_bench.sv */
// self-checking bench for the pll divider control block
`timescale 1ns/1ps
module pll_divider_control_bench
	import pdc_pkg::*;
;
	logic          pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, drop_lock = 0;
	logic [11:0]   paddr = 0;
	logic [31:0]   pwdata = 0, rd_val, prdata;
	logic [3:0]    pstrb = 0;
	logic          pready, pslverr, lock, err;
	logic [6:0]    nv;
	logic [9:0]    rv;
	pdc_core_ctl_t core_ctl;
	int            err_count = 0, samples_checked = 0, seed = 48, n;
	always #12.5 pclk = ~pclk;
	pdc_pll_divider_control DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.pready, .prdata, .pslverr, .phase_compare_lock_detect(lock), .core_ctl);
	pdc_core_model u_core (.pclk, .presetn, .core_ctl, .drop_lock, .lock);
	function automatic logic [31:0] ctl(input logic [1:0] lo, input logic res, en, lk);
		return {24'h00_0000, lo, 2'b00, res, 1'b0, en, lk};
	endfunction : ctl
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int k;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd_val = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(0, a, 32'h0000_0000, 4'h0);
		chk(rd_val, exp);
	endtask : rd
	task automatic report_and_stop;
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		report_and_stop();
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1;
		rd(PDC_ADDR_CONTROL, 32'h0000_0008);
		rd(PDC_ADDR_REF_DIV, 32'h0000_0000);
		rd(PDC_ADDR_FB_HIGH, 32'h0000_0000);
		chk(32'(core_ctl.hold_reset), 32'h0000_0001);
		$display("test reset done");
		for (int i = 0; i < 5; i++) begin
			nv = (i == 0) ? 7'h7f : 7'($random(seed));
			rv = (i == 0) ? 10'h3ff : 10'($random(seed));
			apb(1, PDC_ADDR_REF_DIV, {25'h0, nv}, 4'hf);
			apb(1, PDC_ADDR_FB_HIGH, {24'h0, rv[9:2]}, 4'hf);
			apb(1, PDC_ADDR_CONTROL, ctl(rv[1:0], 1, 0, 1), 4'hf);
			rd(PDC_ADDR_REF_DIV, {25'h0, nv});
			rd(PDC_ADDR_FB_HIGH, {24'h0, rv[9:2]});
			rd(PDC_ADDR_CONTROL, ctl(rv[1:0], 1, 0, 0));
			chk(32'(core_ctl.fb_div_value), 32'(rv));
			chk(32'(core_ctl.ref_div_value), 32'(nv));
		end
		$display("test dividers done");
		apb(1, PDC_ADDR_CONTROL, ctl(0, 1, 1, 0), 4'hf);
		repeat (40) @(posedge pclk);
		rd(PDC_ADDR_CONTROL, ctl(0, 1, 1, 0));
		chk(32'(core_ctl.run_enable), 32'h0000_0000);
		apb(1, PDC_ADDR_CONTROL, ctl(0, 0, 1, 0), 4'hf);
		@(posedge pclk);
		@(negedge pclk);
		chk(32'(core_ctl.run_enable), 32'h0000_0001);
		n = 0;
		do begin
			apb(0, PDC_ADDR_CONTROL, 32'h0000_0000, 4'h0);
			n++;
		end while (rd_val[0] !== 1'b1 && n < 100);
		chk(rd_val, ctl(0, 0, 1, 1));
		drop_lock <= 1;
		repeat (2) @(posedge pclk);
		rd(PDC_ADDR_CONTROL, ctl(0, 0, 1, 0));
		drop_lock <= 0;
		$display("test lock done");
		apb(1, 12'h3a8, 32'h0000_00ff, 4'hf);
		chk(32'(err), 32'h0000_0001);
		rd(12'h3a8, 32'h0000_0000);
		apb(1, PDC_ADDR_REF_DIV, 32'h0000_0055, 4'h0);
		rd(PDC_ADDR_REF_DIV, {25'h0, nv});
		presetn <= 0;
		@(posedge pclk);
		presetn <= 1;
		rd(PDC_ADDR_CONTROL, 32'h0000_0008);
		$display("test refusal done");
		report_and_stop();
	end
endmodule : pll_divider_control_bench
